// file: design/brq_pkg.sv
// Shared constants and types of the request-channel initiator.
// Assumes one rising-edge clock and a synchronous active-low reset.

package brq_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Command codes on the two-bit command field
  localparam logic [1:0] BRQ_CMD_NOP    = 2'h0;
  localparam logic [1:0] BRQ_CMD_READ   = 2'h1;
  localparam logic [1:0] BRQ_CMD_WRITE  = 2'h2;
  localparam logic [1:0] BRQ_CMD_LOCKRD = 2'h3;

  ////////////////////////////////////////////////////////////////////////////
  // Default geometry
  localparam int BRQ_CELL_BYTES = 4;
  localparam int BRQ_ADDR_W     = 32;
  localparam int BRQ_PLEN_W     = 9;
  localparam int BRQ_PLEN_W_MAX = 9;
  localparam int BRQ_CLEN_W     = 8;
  localparam int BRQ_FIFO_DEPTH = 16;

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer states
  typedef enum logic [1:0] {
    BRQ_IDLE,
    BRQ_FILL,
    BRQ_SEND
  } brq_state_t;

endpackage : brq_pkg

// file: design/brq_fifo.sv
// Write-data FIFO with registered read data.
// Assumes one clock and a synchronous active-low reset.

`timescale 1ns/10ps
`default_nettype none

module brq_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16
) (
  input  wire logic             clk,
  input  wire logic             resetn,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);

  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
    $error("brq_fifo: DEPTH must be a power of two, at least 2");
  end

  typedef struct packed {
    logic [PW-1:0]    wp;
    logic [PW-1:0]    rp;
    logic [CW-1:0]    cnt;
    logic             ovalid;
    logic [WIDTH-1:0] odata;
  } brq_fifo_regs_t;

  brq_fifo_regs_t   r;
  brq_fifo_regs_t   next_r;
  logic [WIDTH-1:0] mem [DEPTH];
  logic             push;
  logic             take;

  ////////////////////////////////////////////////////////////////////////////
  // Flow control
  assign in_ready  = r.cnt != CW'(DEPTH);
  assign out_valid = r.ovalid;
  assign out_data  = r.odata;
  assign push      = in_valid && in_ready;
  assign take      = (r.cnt != '0) && (!r.ovalid || out_ready);

  always_comb begin
    next_r = r;
    if (out_ready) begin
      next_r.ovalid = 1'b0;
    end
    if (take) begin
      next_r.odata  = mem[r.rp];
      next_r.ovalid = 1'b1;
      next_r.rp     = r.rp + PW'(1);
    end
    if (push) begin
      next_r.wp = r.wp + PW'(1);
    end
    next_r.cnt = r.cnt + CW'(push) - CW'(take);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Storage
  always_ff @(posedge clk) begin
    if (push) begin
      mem[r.wp] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

endmodule : brq_fifo

`default_nettype wire

// file: design/brq_initiator.sv
// Initiator end of a request channel: turns user packet requests into cells.
// Assumes the target acknowledges cells and that clk and resetn are shared.
//
// What this block does
// - Hold valid and every request field steady until acknowledge seen.
// - Raise valid only for requests the user aims at this target.
// - A cell moves on the edge sampling valid and acknowledge high.
// - Drop valid the edge after acceptance unless another cell of the same packet is loaded.
// - Command codes: 00 no-op, 01 read, 10 write, 11 locked read.
// - Command field holds a legal code whenever valid is high.
// - End-of-packet low promises next cell at next higher address, same address in constant mode, wrap base at window end.
// - Packet completes when a cell with end-of-packet transfers.
// - Chain-fixed keeps command, modes and length same across chain.
// - Chain length counts packets left; the last carries zero.
// - Contiguous steps by cell size; partial edge cells by bytes moved.
// - Packet length in bytes, legal range one to 511.
// - Zero length means undefined; packet ends on end-of-packet.
// - Packet length stays equal on every cell of a packet.
// - Length ties first and last active byte enables to cell count.
// - During reset valid stays low so the channel rests idle.
// - Write data valid whenever valid is high on a write.

`timescale 1ns/10ps
`default_nettype none

module brq_initiator
  import brq_pkg::*;
#(
  parameter int BYTES  = BRQ_CELL_BYTES,
  parameter int ADDR_W = BRQ_ADDR_W,
  parameter int PLEN_W = BRQ_PLEN_W,
  parameter int CLEN_W = BRQ_CLEN_W,
  parameter int FDEPTH = BRQ_FIFO_DEPTH
) (
  input  wire logic                 clk,
  input  wire logic                 resetn,
  // User request port
  input  wire logic                 req_valid,
  output logic                      req_ready,
  input  wire logic [1:0]           req_cmd,
  input  wire logic [ADDR_W-1:0]    req_addr,
  input  wire logic [PLEN_W-1:0]    req_plen,
  input  wire logic [PLEN_W-1:0]    req_ncells,
  input  wire logic                 req_contig,
  input  wire logic                 req_wrap,
  input  wire logic                 req_const,
  input  wire logic [CLEN_W-1:0]    req_clen,
  // User write data
  input  wire logic                 wr_valid,
  output logic                      wr_ready,
  input  wire logic [8*BYTES-1:0]   wr_data,
  // User status
  output logic                      busy,
  output logic                      pkt_done,
  output logic                      chain_done,
  // Request channel pins
  output logic                      vci_cmdval,
  input  wire logic                 vci_cmdack,
  output logic      [1:0]           vci_cmd,
  output logic      [ADDR_W-1:0]    vci_address,
  output logic      [BYTES-1:0]     vci_be,
  output logic      [8*BYTES-1:0]   vci_wdata,
  output logic                      vci_eop,
  output logic                      vci_cfixed,
  output logic      [CLEN_W-1:0]    vci_clen,
  output logic                      vci_contig,
  output logic                      vci_wrap,
  output logic                      vci_const_addr,
  output logic      [PLEN_W-1:0]    vci_plen
);

  localparam int OFFW = $clog2(BYTES);
  localparam int XW   = PLEN_W + 1;

  if (BYTES < 2 || (BYTES & (BYTES - 1)) != 0) begin : g_chk_bytes
    $error("brq_initiator: BYTES must be a power of two, at least 2");
  end
  if (PLEN_W > BRQ_PLEN_W_MAX || (1 << PLEN_W) < BYTES) begin : g_chk_plen
    $error("brq_initiator: PLEN_W out of range");
  end
  if (ADDR_W <= OFFW + PLEN_W) begin : g_chk_addr
    $error("brq_initiator: ADDR_W too narrow");
  end

  typedef struct packed {
    brq_state_t           st;
    logic                 cmdval;
    logic [1:0]           cmd;
    logic [ADDR_W-1:0]    address;
    logic [BYTES-1:0]     be;
    logic [8*BYTES-1:0]   wdata;
    logic                 eop;
    logic                 cfixed;
    logic [CLEN_W-1:0]    clen;
    logic                 contig;
    logic                 wrap;
    logic                 cnst;
    logic [PLEN_W-1:0]    plen;
    logic [ADDR_W-1:0]    start;
    logic [ADDR_W-1:0]    nxt_addr;
    logic [PLEN_W-1:0]    rem;
    logic [PLEN_W-1:0]    ncell;
    logic [PLEN_W-1:0]    ncell_init;
    logic                 pkt_done;
    logic                 chain_done;
  } brq_regs_t;

  brq_regs_t            r;
  brq_regs_t            next_r;

  logic                 f_valid;
  logic                 f_ready;
  logic [8*BYTES-1:0]   f_data;

  logic                 is_write;
  logic                 is_nop;
  logic                 undef_len;
  logic                 can_load;
  logic                 load;
  logic [XW-1:0]        off_x;
  logic [XW-1:0]        room;
  logic [XW-1:0]        rem_x;
  logic                 cell_last;
  logic [PLEN_W-1:0]    moved;
  logic [BYTES-1:0]     cell_be;
  logic [ADDR_W-1:0]    aligned;
  logic [ADDR_W-1:0]    plen_a;
  logic [ADDR_W-1:0]    wbase;
  logic [ADDR_W-1:0]    wlim;
  logic                 pow2;
  logic                 wrap_en;
  logic [ADDR_W-1:0]    adv_addr;

  ////////////////////////////////////////////////////////////////////////////
  // Write data buffer
  brq_fifo #(
    .WIDTH (8*BYTES),
    .DEPTH (FDEPTH)
  ) u_fifo (
    .clk       (clk),
    .resetn    (resetn),
    .in_valid  (wr_valid),
    .in_ready  (wr_ready),
    .in_data   (wr_data),
    .out_valid (f_valid),
    .out_ready (f_ready),
    .out_data  (f_data)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Next cell geometry
  assign is_write  = r.cmd == BRQ_CMD_WRITE;
  assign is_nop    = r.cmd == BRQ_CMD_NOP;
  assign undef_len = r.plen == '0;
  assign can_load  = !is_write || f_valid;
  assign off_x     = XW'(r.nxt_addr[OFFW-1:0]);
  assign room      = XW'(BYTES) - off_x;
  assign rem_x     = {1'b0, r.rem};

  always_comb begin
    if (is_nop) begin
      cell_last = 1'b1;
    end else if (undef_len) begin
      cell_last = r.ncell <= PLEN_W'(1);
    end else begin
      cell_last = rem_x <= room;
    end
  end

  // Partial first and last cells count only the bytes they move
  assign moved = (cell_last && !undef_len) ? r.rem : room[PLEN_W-1:0];

  // Active lanes span from the start offset to the last byte left
  for (genvar i = 0; i < BYTES; i++) begin : g_be
    localparam logic [XW-1:0] LANE = XW'(i);
    assign cell_be[i] = !is_nop && (LANE >= off_x)
                        && (undef_len || (LANE - off_x) < rem_x);
  end

  assign aligned  = {r.nxt_addr[ADDR_W-1:OFFW], OFFW'(0)} + ADDR_W'(BYTES);
  assign plen_a   = ADDR_W'(r.plen);
  assign wbase    = r.start & ~(plen_a - ADDR_W'(1));
  assign wlim     = wbase + plen_a;
  assign pow2     = !undef_len && ((r.plen & (r.plen - PLEN_W'(1))) == '0);
  assign wrap_en  = r.contig && r.wrap && !r.cnst && pow2;

  always_comb begin
    if (r.cnst) begin
      adv_addr = r.nxt_addr;
    end else if (wrap_en && aligned >= wlim) begin
      adv_addr = wbase;
    end else begin
      adv_addr = aligned;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer
  always_comb begin
    next_r            = r;
    load              = 1'b0;
    next_r.pkt_done   = 1'b0;
    next_r.chain_done = 1'b0;
    case (r.st)
      BRQ_IDLE: begin
        if (req_valid) begin
          next_r.cmd        = req_cmd;
          next_r.start      = req_addr;
          next_r.nxt_addr   = req_addr;
          next_r.plen       = req_plen;
          next_r.rem        = req_plen;
          next_r.ncell      = req_ncells;
          next_r.ncell_init = req_ncells;
          next_r.contig     = req_contig;
          next_r.wrap       = req_wrap;
          next_r.cnst       = req_const;
          next_r.clen       = req_clen;
          next_r.cfixed     = req_clen != '0;
          next_r.st         = BRQ_FILL;
        end
      end
      BRQ_FILL: begin
        if (can_load) begin
          load      = 1'b1;
          next_r.st = BRQ_SEND;
        end
      end
      BRQ_SEND: begin
        if (vci_cmdack) begin
          if (r.eop) begin
            next_r.cmdval   = 1'b0;
            next_r.pkt_done = 1'b1;
            if (r.clen == '0) begin
              next_r.chain_done = 1'b1;
              next_r.st         = BRQ_IDLE;
            end else begin
              // Same fields and address pattern for the next packet
              next_r.clen     = r.clen - CLEN_W'(1);
              next_r.nxt_addr = r.start;
              next_r.rem      = r.plen;
              next_r.ncell    = r.ncell_init;
              next_r.st       = BRQ_FILL;
            end
          end else if (can_load) begin
            load = 1'b1;
          end else begin
            next_r.cmdval = 1'b0;
            next_r.st     = BRQ_FILL;
          end
        end
      end
      default: begin
        next_r.st     = BRQ_IDLE;
        next_r.cmdval = 1'b0;
      end
    endcase
    if (load) begin
      next_r.cmdval   = 1'b1;
      next_r.address  = r.nxt_addr;
      next_r.be       = cell_be;
      next_r.eop      = cell_last;
      next_r.wdata    = is_write ? f_data : '0;
      next_r.nxt_addr = adv_addr;
      next_r.rem      = r.rem - moved;
      next_r.ncell    = r.ncell - PLEN_W'(1);
    end
  end

  // Buffer head leaves only when copied into the cell register
  assign f_ready = load && is_write;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign req_ready      = r.st == BRQ_IDLE;
  assign busy           = r.st != BRQ_IDLE;
  assign pkt_done       = r.pkt_done;
  assign chain_done     = r.chain_done;
  assign vci_cmdval     = r.cmdval;
  assign vci_cmd        = r.cmd;
  assign vci_address    = r.address;
  assign vci_be         = r.be;
  assign vci_wdata      = r.wdata;
  assign vci_eop        = r.eop;
  assign vci_cfixed     = r.cfixed;
  assign vci_clen       = r.clen;
  assign vci_contig     = r.contig;
  assign vci_wrap       = r.wrap;
  assign vci_const_addr = r.cnst;
  assign vci_plen       = r.plen;

endmodule : brq_initiator

`default_nettype wire

// file: testbench/brq_chk.sv
// Checker for the request-channel pins of the initiator.
// Bound into brq_initiator; sees its ports only.
`timescale 1ns/10ps
`default_nettype none
module brq_chk
  import brq_pkg::*;
#(
  parameter int BYTES  = 4,
  parameter int ADDR_W = 32,
  parameter int PLEN_W = 9,
  parameter int CLEN_W = 8
) (
  input wire logic              clk,
  input wire logic              resetn,
  input wire logic              pkt_done,
  input wire logic              chain_done,
  input wire logic              vci_cmdval,
  input wire logic              vci_cmdack,
  input wire logic [1:0]        vci_cmd,
  input wire logic [ADDR_W-1:0] vci_address,
  input wire logic [BYTES-1:0]  vci_be,
  input wire logic              vci_eop,
  input wire logic [CLEN_W-1:0] vci_clen,
  input wire logic              vci_contig,
  input wire logic              vci_wrap,
  input wire logic              vci_const_addr,
  input wire logic [PLEN_W-1:0] vci_plen
);
  logic              hs;
  logic              in_pkt;
  logic [ADDR_W-1:0] last_a;
  logic [ADDR_W-1:0] base;
  logic [ADDR_W-1:0] nxt;
  logic [PLEN_W-1:0] last_p;

  assign hs = vci_cmdval && vci_cmdack;
  always_ff @(posedge clk) begin
    if (!resetn) begin
      in_pkt <= 1'b0;
    end else if (hs) begin
      in_pkt <= !vci_eop;
    end
  end
  always_ff @(posedge clk) begin
    if (hs) begin
      last_a <= vci_address;
      last_p <= vci_plen;
    end
    if (hs && !in_pkt) begin
      base <= vci_address & ~ADDR_W'(vci_plen - 1'b1);
    end
  end
  always_comb begin
    nxt = (last_a & ~ADDR_W'(BYTES - 1)) + ADDR_W'(BYTES);
    if (vci_contig && vci_wrap && last_p != 0 && (last_p & (last_p - 1'b1)) == 0
        && nxt == base + ADDR_W'(last_p)) begin
      nxt = base;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  property p_hold;
    vci_cmdval && !vci_cmdack |=> vci_cmdval && $stable(vci_address) && $stable(vci_cmd)
      && $stable(vci_be) && $stable(vci_eop) && $stable(vci_plen);
  endproperty
  a_hold: assert property (p_hold) else $error("request changed before ack");
  property p_drop;
    hs && vci_eop |=> !vci_cmdval;
  endproperty
  a_drop: assert property (p_drop) else $error("valid kept after last cell");
  property p_pkt;
    hs && vci_eop |=> pkt_done;
  endproperty
  a_pkt: assert property (p_pkt) else $error("no packet done after end cell");
  property p_last;
    hs && vci_eop && vci_clen == 0 |=> chain_done;
  endproperty
  a_last: assert property (p_last) else $error("no chain done on last packet");
  property p_chain;
    hs && vci_eop && vci_clen != 0 |=> !chain_done ##1 vci_cmdval
      && vci_clen == $past(vci_clen, 2) - 1'b1 && vci_cmd == $past(vci_cmd, 2)
      && vci_plen == $past(vci_plen, 2);
  endproperty
  a_chain: assert property (p_chain) else $error("chain packet fields wrong");
  property p_plen;
    vci_cmdval && in_pkt |-> vci_plen == last_p;
  endproperty
  a_plen: assert property (p_plen) else $error("length changed in packet");
  property p_step;
    vci_cmdval && in_pkt && !vci_const_addr |-> vci_address == nxt;
  endproperty
  a_step: assert property (p_step) else $error("next cell address wrong");
  property p_const;
    vci_cmdval && in_pkt && vci_const_addr |-> vci_address == last_a;
  endproperty
  a_const: assert property (p_const) else $error("constant address moved");
  property p_nop;
    vci_cmdval && vci_cmd == BRQ_CMD_NOP |-> vci_eop && vci_be == '0;
  endproperty
  a_nop: assert property (p_nop) else $error("no-op cell moves data");
  property p_idle;
    $rose(resetn) |-> !vci_cmdval && !pkt_done;
  endproperty
  a_idle: assert property (p_idle) else $error("channel busy out of reset");
endmodule : brq_chk

bind brq_initiator brq_chk #(.BYTES(BYTES), .ADDR_W(ADDR_W), .PLEN_W(PLEN_W),
  .CLEN_W(CLEN_W)) brq_chk_i (.*);
`default_nettype wire

// file: testbench/brq_target.sv
// Target model: acknowledges cells, stores write bytes.
// Assumes byte address space of 256 and clk shared with the initiator.
`timescale 1ns/10ps
`default_nettype none
module brq_target
  import brq_pkg::*;
#(
  parameter int BYTES  = 4,
  parameter int ADDR_W = 32
) (
  input wire logic               clk,
  input wire logic               resetn,
  input wire logic               slow,
  input wire logic               vci_cmdval,
  output logic                   vci_cmdack,
  input wire logic [1:0]         vci_cmd,
  input wire logic [ADDR_W-1:0]  vci_address,
  input wire logic [BYTES-1:0]   vci_be,
  input wire logic [8*BYTES-1:0] vci_wdata
);
  logic [7:0]  mem [256];
  logic [15:0] lfsr;

  initial begin
    lfsr = 16'hACE1;
    vci_cmdack = 1'b0;
    for (int i = 0; i < 256; i++) mem[i] = 8'h5A;
  end
  always @(posedge clk) begin
    if (resetn && vci_cmdval && vci_cmdack && vci_cmd == BRQ_CMD_WRITE) begin
      for (int i = 0; i < BYTES; i++) begin
        if (vci_be[i]) mem[8'((vci_address & ~ADDR_W'(BYTES - 1)) + ADDR_W'(i))] =
          vci_wdata[8*i +: 8];
      end
    end
    lfsr <= {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    vci_cmdack <= #1 resetn && (!slow || lfsr[0]);
  end
endmodule : brq_target
`default_nettype wire

// file: testbench/testbench.sv
// Self-checking bench of the request-channel initiator.
// Assumes brq_pkg defaults and the target model beside it.
`timescale 1ns/10ps
`default_nettype none
module testbench
  import brq_pkg::*;
;
  localparam int B = BRQ_CELL_BYTES;
  logic        clk, resetn, slow, req_valid, req_ready, req_contig, req_wrap, req_const;
  logic        wr_valid, wr_ready, busy, pkt_done, chain_done, vci_cmdval, vci_cmdack;
  logic        vci_eop, vci_cfixed, vci_contig, vci_wrap, vci_const_addr;
  logic [1:0]  req_cmd, vci_cmd;
  logic [3:0]  vci_be;
  logic [7:0]  req_clen, vci_clen;
  logic [8:0]  req_plen, req_ncells, vci_plen;
  logic [31:0] req_addr, wr_data, vci_address, vci_wdata, seed, r;
  logic [31:0] words[$];
  logic [31:0] ws[$];
  int          n_fail, compares, n;

  brq_initiator brq_initiator_i (.*);
  brq_target brq_target_i (.*);

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  task automatic check(string what, logic [95:0] seen, logic [95:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic print_verdict();
    $display("compares %0d mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : print_verdict
  task automatic push(int cnt);
    repeat (cnt) begin
      wr_data = rnd();
      wr_valid = 1'b1;
      while (!wr_ready) @(posedge clk) #1;
      words.push_back(wr_data);
      @(posedge clk) #1;
    end
    wr_valid = 1'b0;
  endtask : push
  task automatic run(logic [1:0] c, logic [31:0] a, logic [8:0] p, nc, logic ct, w, k,
                     logic [7:0] cl);
    logic [95:0] exp_c, got_c;
    logic [31:0] x, base, wd;
    logic [3:0]  eb;
    logic        e;
    int          rem, off, cn, t;
    {req_cmd, req_addr, req_plen, req_ncells} = {c, a, p, nc};
    {req_contig, req_wrap, req_const, req_clen, req_valid} = {ct, w, k, cl, 1'b1};
    @(posedge clk) #1;
    req_valid = 1'b0;
    base = a & ~(32'(p) - 1);
    for (int pk = 0; pk <= cl; pk++) begin
      x = a;
      rem = p;
      cn = 0;
      do begin
        t = 0;
        do begin
          @(negedge clk);
          t++;
        end while (!(vci_cmdval && vci_cmdack) && t < 300);
        check("ack", t < 300, 1'b1);
        off = x % B;
        n = (p == 0 || rem > B - off) ? B - off : rem;
        rem -= n;
        cn++;
        e = (c == BRQ_CMD_NOP) || (p != 0 ? rem <= 0 : cn >= nc);
        eb = (c == BRQ_CMD_NOP) ? 4'h0 : (p == 0) ? 4'(4'hF << off) : 4'((1 << n) - 1) << off;
        wd = (c == BRQ_CMD_WRITE) ? words.pop_front() : 32'h0;
        exp_c = {ct, w, k, c, e, cl != 0, 8'(cl - pk), eb, p, x, wd};
        got_c = {vci_contig, vci_wrap, vci_const_addr, vci_cmd, vci_eop, vci_cfixed, vci_clen,
                 vci_be, vci_plen, vci_address, vci_wdata};
        check("cell", got_c, exp_c);
        x = k ? x : (x & ~32'h3) + 32'h4;
        if (ct && w && !k && p != 0 && (p & (p - 1)) == 0 && x == base + p) x = base;
      end while (!e);
    end
    @(posedge clk);
    @(negedge clk);
    check("done", {chain_done, pkt_done}, 2'b11);
    @(posedge clk) #1;
    check("ready", req_ready, 1'b1);
    $display("test cmd %0d addr %h plen %0d done", c, a, p);
  endtask : run

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #400000;
    n_fail++;
    print_verdict();
  end
  initial begin
    seed = 32'hE75773C0;
    {req_valid, req_cmd, req_addr, req_plen, req_ncells, req_contig} = '0;
    {req_wrap, req_const, req_clen, wr_valid, wr_data, slow} = '0;
    resetn = 1'b0;
    repeat (10) @(posedge clk);
    #1 resetn = 1'b1;
    check("idle", {req_ready, wr_ready, vci_cmdval}, 3'b110);
    run(BRQ_CMD_READ, 32'h2, 9'd8, 9'd0, 1, 0, 0, 0);
    push(4);
    ws = words;
    run(BRQ_CMD_WRITE, 32'h1, 9'd12, 9'd0, 1, 0, 0, 0);
    for (int j = 0; j < 16; j++) begin
      r = (j >= 1 && j < 13) ? ws[j / 4][8 * (j % 4) +: 8] : 8'h5A;
      check("mem", brq_target_i.mem[j], r);
    end
    run(BRQ_CMD_NOP, 32'h20, 9'd4, 9'd0, 1, 0, 0, 0);
    run(BRQ_CMD_LOCKRD, 32'h1C, 9'd16, 9'd0, 1, 1, 0, 0);
    run(BRQ_CMD_READ, 32'h41, 9'd8, 9'd0, 0, 0, 1, 0);
    slow = 1'b1;
    run(BRQ_CMD_READ, 32'h8, 9'd4, 9'd0, 1, 0, 0, 8'd2);
    run(BRQ_CMD_READ, 32'h30, 9'd0, 9'd3, 1, 1, 0, 0);
    n = 0;
    wr_valid = 1'b1;
    while (wr_ready && n < 20) begin
      wr_data = rnd();
      words.push_back(wr_data);
      n++;
      @(posedge clk) #1;
    end
    wr_valid = 1'b0;
    check("fill", n, 17);
    run(BRQ_CMD_WRITE, 32'h80, 9'd68, 9'd0, 1, 0, 0, 0);
    check("drained", {wr_ready, busy}, 2'b10);
    repeat (30) begin
      r = rnd();
      slow = r[20];
      n = (r[7:0] % 4 + r[12:8] % 24 + 4) / 4 * (r[14] + 1);
      if (r[1:0] == BRQ_CMD_WRITE) push(n);
      run(r[1:0], {24'h0, r[7:0]}, 9'(r[12:8] % 24 + 1), 9'd0, r[15], r[16],
          r[17] && r[1:0] != BRQ_CMD_WRITE, {7'h0, r[14]});
    end
    print_verdict();
  end
endmodule : testbench
`default_nettype wire
